// ==== logic/csil_defs.svh ====
// Purpose: offsets, field positions, reset values and counts of the
//          status word and vector level block
// Assumes: register indices are word indices; byte address is index*4
// Notes:   definitions only
`ifndef CSIL_DEFS_SVH
`define CSIL_DEFS_SVH
`define CSIL_IDX_LVL_AL 16'h7f02
`define CSIL_IDX_LVL_AH 16'h7f03
`define CSIL_IDX_LVL_BL 16'h7f04
`define CSIL_IDX_LVL_BH 16'h7f05
`define CSIL_IDX_PSW 16'h7f10
`define CSIL_IDX_STAT 16'h7f11
`define CSIL_IDX_MASK 16'h7f12
`define CSIL_PSW_Z8 0
`define CSIL_PSW_Z16 1
`define CSIL_PSW_CY 2
`define CSIL_PSW_HC 3
`define CSIL_PSW_OV 4
`define CSIL_PSW_P 5
`define CSIL_PSW_S 6
`define CSIL_PSW_IE 7
`define CSIL_PSW_IL_LSB 8
`define CSIL_PSW_WS 11
`define CSIL_PSW_N_LSB 12
`define CSIL_PSW_RST 16'h0000
`define CSIL_LVL_RST 8'h00
`define CSIL_EV_RST 3'h0
`define CSIL_EV_ENTRY 0
`define CSIL_EV_RET 1
`define CSIL_EV_EXCBLK 2
`define CSIL_VEC_BASE 16'h8000
`define CSIL_ENTRY_CYC 3
`endif

// ==== logic/csil_pkg.sv ====
// Purpose: types shared by the status word and vector level block
// Assumes: one clock domain
// Notes:   op kinds are one-hot
package csil_pkg;
  typedef enum logic [5:0] {
    CSIL_OP_XFER8 = 6'h01,
    CSIL_OP_XFER16 = 6'h02,
    CSIL_OP_ARITH = 6'h04,
    CSIL_OP_SHIFT = 6'h08,
    CSIL_OP_MDIV_U = 6'h10,
    CSIL_OP_MDIV_S = 6'h20
  } csil_op_e;
  typedef struct packed {
    logic valid;
    csil_op_e kind;
    logic [15:0] result;
    logic carry;
    logic half_carry;
    logic overflow;
    logic [3:0] reg_index;
  } csil_op_t;
  typedef struct packed {
    logic push_valid;
    logic [15:0] push_data;
    logic branch_valid;
    logic [15:0] vector;
  } csil_entry_t;
  typedef enum logic [3:0] {
    CSIL_ST_IDLE = 4'h1,
    CSIL_ST_PUSH_PC = 4'h2,
    CSIL_ST_PUSH_PSW = 4'h4,
    CSIL_ST_BRANCH = 4'h8
  } csil_state_e;
endpackage : csil_pkg

// ==== logic/csil_top.sv ====
// Purpose: cpu status word, vector level registers and interrupt accept
// Assumes: requests and core strobes come from logic on hclk
// Notes:   ahb-lite slave, zero wait states, always okay
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ns
`include "csil_defs.svh"
module csil_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // cpu core
  input wire csil_pkg::csil_op_t op,
  input wire logic psw_wr_en,
  input wire logic [15:0] psw_wr_data,
  input wire logic instr_boundary,
  input wire logic [15:0] cur_pc,
  input wire logic return_from_handler,
  input wire logic [15:0] ret_psw,
  output logic [15:0] cpu_status_word,
  output csil_pkg::csil_entry_t entry,
  // exception control write gate
  input wire logic exc_wr_req,
  output logic exc_wr_grant,
  // peripheral requests
  input wire logic [15:0] irq_req,
  output logic irq_o
);
  import csil_pkg::*;

  localparam logic [31:0] A_LVL0 = {14'h0000, `CSIL_IDX_LVL_AL, 2'b00};
  localparam logic [31:0] A_LVL1 = {14'h0000, `CSIL_IDX_LVL_AH, 2'b00};
  localparam logic [31:0] A_LVL2 = {14'h0000, `CSIL_IDX_LVL_BL, 2'b00};
  localparam logic [31:0] A_LVL3 = {14'h0000, `CSIL_IDX_LVL_BH, 2'b00};
  localparam logic [31:0] A_PSW = {14'h0000, `CSIL_IDX_PSW, 2'b00};
  localparam logic [31:0] A_STAT = {14'h0000, `CSIL_IDX_STAT, 2'b00};
  localparam logic [31:0] A_MASK = {14'h0000, `CSIL_IDX_MASK, 2'b00};
  localparam int ENTRY_CYC = `CSIL_ENTRY_CYC;

  logic [15:0] psw_ff;
  logic [15:0] nxt_psw;
  logic [7:0] lvl_ff [4];
  logic [2:0] stat_ff;
  logic [2:0] mask_ff;
  logic ap_wr_ff;
  logic [31:0] ap_addr_ff;
  logic hold_ff;
  csil_state_e st_ff;
  csil_state_e nxt_st;
  logic [15:0] push_data_ff;
  logic [15:0] psw_save_ff;
  logic [15:0] vec_ff;

  // bus address phase; hsize is not checked, only word transfers occur
  wire ahb_go = hsel && htrans[1] && hready;
  wire hit_psw = (ap_addr_ff == A_PSW);
  wire hit_stat = (ap_addr_ff == A_STAT);
  wire hit_mask = (ap_addr_ff == A_MASK);
  wire [3:0] hit_lvl = {ap_addr_ff == A_LVL3, ap_addr_ff == A_LVL2,
                        ap_addr_ff == A_LVL1, ap_addr_ff == A_LVL0};
  wire [3:0] wr_lvl = hit_lvl & {4{ap_wr_ff}};
  wire wr_psw = ap_wr_ff && hit_psw;
  wire wr_stat = ap_wr_ff && hit_stat;
  wire wr_mask = ap_wr_ff && hit_mask;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_ff <= 1'b0;
      ap_addr_ff <= 32'h0000_0000;
    end else begin
      ap_wr_ff <= ahb_go && hwrite;
      ap_addr_ff <= ahb_go ? haddr : ap_addr_ff;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // read data is chosen in the data phase so a write just before is seen
  assign hrdata = hit_psw ? {16'h0000, psw_ff} :
                  hit_lvl[0] ? {24'h00_0000, lvl_ff[0]} :
                  hit_lvl[1] ? {24'h00_0000, lvl_ff[1]} :
                  hit_lvl[2] ? {24'h00_0000, lvl_ff[2]} :
                  hit_lvl[3] ? {24'h00_0000, lvl_ff[3]} :
                  hit_stat ? {29'h0000_0000, stat_ff} :
                  hit_mask ? {29'h0000_0000, mask_ff} : 32'h0000_0000;

  // level registers, four 2-bit fields each
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < 4; k++) begin
        lvl_ff[k] <= `CSIL_LVL_RST;
      end
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (wr_lvl[k]) begin
          lvl_ff[k] <= hwdata[7:0];
        end
      end
    end
  end

  wire [2:0] cur_il = psw_ff[`CSIL_PSW_IL_LSB +: 3];
  wire ie = psw_ff[`CSIL_PSW_IE];
  logic [1:0] vlvl [16];
  logic [15:0] elig;
  logic [15:0] m3;
  logic [15:0] m2;
  logic [15:0] m1;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_vec
      // vector 8000h+4*gi sits in register gi/4, field gi%4
      assign vlvl[gi] = lvl_ff[gi / 4][(gi % 4) * 2 +: 2];
      assign elig[gi] = irq_req[gi] && (vlvl[gi] != 2'b00) &&
                        ({1'b0, vlvl[gi]} > cur_il);
      assign m3[gi] = elig[gi] && (vlvl[gi] == 2'b11);
      assign m2[gi] = elig[gi] && (vlvl[gi] == 2'b10);
      assign m1[gi] = elig[gi] && (vlvl[gi] == 2'b01);
    end
  endgenerate

  function automatic logic [3:0] csil_lowest(input logic [15:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int j = 15; j >= 0; j--) begin
      if (m[j]) begin
        r = 4'(j);
      end
    end
    return r;
  endfunction : csil_lowest

  wire [15:0] sel_mask = (|m3) ? m3 : (|m2) ? m2 : m1;
  wire [3:0] win_idx = csil_lowest(sel_mask);
  wire [1:0] win_lvl = vlvl[win_idx];
  wire [15:0] win_vec = `CSIL_VEC_BASE + {10'h000, win_idx, 2'b00};

  // no acceptance at the boundary right after a return
  wire accept = (st_ff == CSIL_ST_IDLE) && ie && instr_boundary &&
                !hold_ff && (|elig);

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      CSIL_ST_IDLE: nxt_st = accept ? CSIL_ST_PUSH_PC : CSIL_ST_IDLE;
      CSIL_ST_PUSH_PC: nxt_st = CSIL_ST_PUSH_PSW;
      CSIL_ST_PUSH_PSW: nxt_st = CSIL_ST_BRANCH;
      CSIL_ST_BRANCH: nxt_st = CSIL_ST_IDLE;
      default: nxt_st = CSIL_ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= CSIL_ST_IDLE;
      hold_ff <= 1'b0;
      push_data_ff <= 16'h0000;
      psw_save_ff <= 16'h0000;
      vec_ff <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
      hold_ff <= return_from_handler ? 1'b1 :
                 instr_boundary ? 1'b0 : hold_ff;
      psw_save_ff <= accept ? psw_ff : psw_save_ff;
      push_data_ff <= accept ? cur_pc :
                      (st_ff == CSIL_ST_PUSH_PC) ? psw_save_ff :
                      push_data_ff;
      vec_ff <= accept ? win_vec : vec_ff;
    end
  end

  assign entry.push_valid = (st_ff == CSIL_ST_PUSH_PC) ||
                            (st_ff == CSIL_ST_PUSH_PSW);
  assign entry.push_data = push_data_ff;
  assign entry.branch_valid = (st_ff == CSIL_ST_BRANCH);
  assign entry.vector = vec_ff;

  // flag update from a finished transfer or operation
  function automatic logic [15:0] csil_flags(input logic [15:0] ps,
                                             input csil_op_t o);
    logic [15:0] p;
    logic b8;
    logic md;
    p = ps;
    b8 = (o.kind == CSIL_OP_XFER8);
    md = (o.kind == CSIL_OP_MDIV_U) || (o.kind == CSIL_OP_MDIV_S);
    p[`CSIL_PSW_Z8] = (o.result[7:0] == 8'h00);
    p[`CSIL_PSW_Z16] = b8 ? (o.result[7:0] == 8'h00) :
                       (o.result == 16'h0000);
    p[`CSIL_PSW_P] = b8 ? ^o.result[7:0] : ^o.result;
    p[`CSIL_PSW_S] = b8 ? o.result[7] : o.result[15];
    if (o.kind == CSIL_OP_ARITH) begin
      p[`CSIL_PSW_CY] = o.carry;
      p[`CSIL_PSW_HC] = o.half_carry;
      p[`CSIL_PSW_OV] = o.overflow;
    end
    if (o.kind == CSIL_OP_SHIFT) begin
      p[`CSIL_PSW_CY] = o.carry;
    end
    if (md) begin
      p[`CSIL_PSW_HC] = 1'b0;
      p[`CSIL_PSW_OV] = 1'b0;
      p[`CSIL_PSW_N_LSB +: 4] = 4'h0;
      p[`CSIL_PSW_CY] = (o.kind == CSIL_OP_MDIV_S) ?
                        p[`CSIL_PSW_S] : 1'b0;
    end else begin
      p[`CSIL_PSW_N_LSB +: 4] = o.reg_index;
    end
    return p;
  endfunction : csil_flags

  // whole-word writes win over flag and level updates in the same cycle
  always_comb begin
    nxt_psw = psw_ff;
    if (op.valid) begin
      nxt_psw = csil_flags(psw_ff, op);
    end
    if (accept) begin
      nxt_psw[`CSIL_PSW_IL_LSB +: 3] = {1'b0, win_lvl};
    end
    if (return_from_handler) begin
      nxt_psw[`CSIL_PSW_IL_LSB +: 3] = ret_psw[`CSIL_PSW_IL_LSB +: 3];
    end
    if (psw_wr_en) begin
      nxt_psw = psw_wr_data;
    end
    if (wr_psw) begin
      nxt_psw = hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psw_ff <= `CSIL_PSW_RST;
    end else begin
      psw_ff <= nxt_psw;
    end
  end

  assign cpu_status_word = psw_ff;
  assign exc_wr_grant = exc_wr_req && psw_ff[`CSIL_PSW_WS];
  wire exc_blocked = exc_wr_req && !psw_ff[`CSIL_PSW_WS];

  // sticky events; a new event wins over a write-one-to-clear
  wire [2:0] ev = {exc_blocked, return_from_handler, accept};
  wire [2:0] w1c = wr_stat ? hwdata[2:0] : 3'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_ff <= `CSIL_EV_RST;
      mask_ff <= `CSIL_EV_RST;
    end else begin
      stat_ff <= (stat_ff & ~w1c) | ev;
      mask_ff <= wr_mask ? hwdata[2:0] : mask_ff;
    end
  end

  assign irq_o = |(stat_ff & mask_ff);

  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  wire upd_ok = !psw_wr_en && !wr_psw;

  sequence s_save;
    entry.push_valid && !entry.branch_valid;
  endsequence
  sequence s_jump;
    entry.branch_valid && !entry.push_valid;
  endsequence

  AST_IE_GATE: assert property (!ie |-> !accept)
    else $error("request accepted with global enable clear");
  AST_ABOVE_LEVEL: assert property (accept |-> ({1'b0, win_lvl} > cur_il)
    && (win_lvl != 2'b00))
    else $error("accepted level not above current level");
  AST_LEVEL_TAKEN: assert property (accept && upd_ok &&
    !return_from_handler |=> cur_il == {1'b0, $past(win_lvl)})
    else $error("current level not raised on acceptance");
  AST_WS_GATE: assert property (exc_wr_req && !psw_ff[`CSIL_PSW_WS]
    |-> !exc_wr_grant ##1 stat_ff[`CSIL_EV_EXCBLK])
    else $error("exception write passed while locked");
  AST_ZERO: assert property (op.valid && upd_ok &&
    op.kind == CSIL_OP_XFER16 |=> psw_ff[`CSIL_PSW_Z16] ==
    ($past(op.result) == 16'h0000))
    else $error("zero flag wrong after transfer");
  AST_CARRY: assert property (op.valid && upd_ok &&
    op.kind == CSIL_OP_ARITH |=> psw_ff[`CSIL_PSW_CY] == $past(op.carry))
    else $error("carry flag not loaded");
  AST_HALF: assert property (op.valid && upd_ok &&
    op.kind == CSIL_OP_ARITH |=> psw_ff[`CSIL_PSW_HC] ==
    $past(op.half_carry))
    else $error("half carry flag not loaded");
  AST_PARITY: assert property (op.valid && upd_ok &&
    op.kind == CSIL_OP_XFER8 |=> psw_ff[`CSIL_PSW_P] ==
    ^$past(op.result[7:0]))
    else $error("parity flag wrong");
  AST_REGIDX: assert property (op.valid && upd_ok &&
    op.kind == CSIL_OP_ARITH |=> psw_ff[15:12] == $past(op.reg_index))
    else $error("register index not loaded");
  AST_MDIV_S: assert property (op.valid && upd_ok &&
    op.kind == CSIL_OP_MDIV_S |=> psw_ff[`CSIL_PSW_CY] ==
    psw_ff[`CSIL_PSW_S] && psw_ff[4:3] == 2'b00 && psw_ff[15:12] == 4'h0)
    else $error("signed divide flags wrong");
  AST_LOWEST: assert property (accept |-> (sel_mask &
    ((16'h0001 << win_idx) - 16'h0001)) == 16'h0000 && !(|m3 && win_lvl != 2'b11))
    else $error("winner is not highest level lowest vector");
  AST_ENTRY_SEQ: assert property (accept |=> s_save ##1 s_save
    ##1 s_jump ##1 !entry.branch_valid)
    else $error("entry sequence not three cycles");
  AST_ENTRY_DATA: assert property (accept |=> entry.push_data ==
    $past(cur_pc) ##1 entry.push_data == $past(psw_ff, 2) ##1
    entry.vector == $past(win_vec, ENTRY_CYC))
    else $error("entry pushed or branched to wrong value");
  AST_RETURN: assert property (return_from_handler && upd_ok |=>
    cur_il == $past(ret_psw[10:8]) && !accept)
    else $error("level not restored on return");
endmodule : csil_top

// ==== bench/csil_core_model.sv ====
// Purpose: core and request-source model facing the entry port
// Assumes: the core reaches an instruction boundary every cycle
// Notes:   keeps the last entry so that the bench can judge it
`timescale 1ns/1ns
module csil_core_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // device side
  input wire csil_pkg::csil_entry_t entry,
  output logic [15:0] irq_req,
  output logic instr_boundary,
  output logic [15:0] cur_pc,
  // bench side
  input wire logic [15:0] req_set,
  output logic [15:0] got_pc,
  output logic [15:0] exp_pc,
  output logic [15:0] got_psw,
  output logic [15:0] got_vec,
  output logic [7:0] n_branch,
  output logic [2:0] span
);
  import csil_pkg::*;
  logic [15:0] pc_prev_ff;
  logic [2:0] k_ff;
  logic in_e_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {irq_req, instr_boundary, cur_pc, pc_prev_ff, got_pc} <= '0;
      {exp_pc, got_psw, got_vec, n_branch, span, k_ff, in_e_ff} <= '0;
    end else begin
      irq_req <= req_set;
      instr_boundary <= 1'b1;
      // pc moves every cycle so a stale push value cannot pass
      cur_pc <= cur_pc + 16'h0002;
      pc_prev_ff <= cur_pc;
      if (entry.push_valid && !in_e_ff) begin
        in_e_ff <= 1'b1;
        k_ff <= 3'h1;
        got_pc <= entry.push_data;
        exp_pc <= pc_prev_ff;
      end else if (entry.push_valid) begin
        got_psw <= entry.push_data;
        k_ff <= k_ff + 3'h1;
      end else if (in_e_ff) begin
        k_ff <= k_ff + 3'h1;
      end
      if (entry.branch_valid) begin
        got_vec <= entry.vector;
        span <= k_ff;
        n_branch <= n_branch + 8'h01;
        in_e_ff <= 1'b0;
      end
    end
  end
endmodule : csil_core_model

// ==== bench/csil_top_bench.sv ====
// Purpose: self-checking bench for the status word and level block
// Assumes: zero-wait ahb slave; registers at word index times four
// Notes:   table rows first, then reset, entry, return and gate cases
`timescale 1ns/1ns
`include "csil_defs.svh"
module csil_top_bench;
  import csil_pkg::*;
  typedef struct packed {
    logic is_op;
    csil_op_e kind;
    logic [31:0] a;
    logic [31:0] d;
    logic [2:0] cho;
    logic [3:0] idx;
    logic [15:0] exp;
  } csil_row_t;
  localparam logic [31:0] A_AL = {14'h0, `CSIL_IDX_LVL_AL, 2'b00};
  localparam logic [31:0] A_AH = {14'h0, `CSIL_IDX_LVL_AH, 2'b00};
  localparam logic [31:0] A_BL = {14'h0, `CSIL_IDX_LVL_BL, 2'b00};
  localparam logic [31:0] A_BH = {14'h0, `CSIL_IDX_LVL_BH, 2'b00};
  localparam logic [31:0] A_PSW = {14'h0, `CSIL_IDX_PSW, 2'b00};
  localparam logic [31:0] A_STAT = {14'h0, `CSIL_IDX_STAT, 2'b00};
  localparam logic [31:0] A_MASK = {14'h0, `CSIL_IDX_MASK, 2'b00};
  // nothing is mapped at this word
  localparam logic [31:0] A_NONE = 32'h0001_fc18;
  localparam csil_row_t ROWS [13] = '{
    '{1'b0, CSIL_OP_XFER8, A_AL, 32'hffff_ff1b, 3'h0, 4'h0, 16'h001b},
    '{1'b0, CSIL_OP_XFER8, A_AH, 32'h0000_00e4, 3'h0, 4'h0, 16'h00e4},
    '{1'b0, CSIL_OP_XFER8, A_BL, 32'h0000_005a, 3'h0, 4'h0, 16'h005a},
    '{1'b0, CSIL_OP_XFER8, A_BH, 32'h0000_00a5, 3'h0, 4'h0, 16'h00a5},
    '{1'b0, CSIL_OP_XFER8, A_NONE, 32'h0000_00ff, 3'h0, 4'h0, 16'h0000},
    '{1'b1, CSIL_OP_XFER16, 32'h0, 32'h0000, 3'h4, 4'h3, 16'h3003},
    '{1'b1, CSIL_OP_XFER16, 32'h0, 32'h8100, 3'h0, 4'h5, 16'h5041},
    '{1'b1, CSIL_OP_XFER8, 32'h0, 32'h1200, 3'h0, 4'h1, 16'h1003},
    '{1'b1, CSIL_OP_ARITH, 32'h0, 32'h0107, 3'h7, 4'h2, 16'h201c},
    '{1'b1, CSIL_OP_SHIFT, 32'h0, 32'h8001, 3'h3, 4'h4, 16'h4058},
    '{1'b1, CSIL_OP_MDIV_U, 32'h0, 32'h0001, 3'h7, 4'h7, 16'h0020},
    '{1'b1, CSIL_OP_MDIV_S, 32'h0, 32'hff00, 3'h0, 4'h7, 16'h0045},
    '{1'b1, CSIL_OP_XFER16, 32'h0, 32'h0000, 3'h0, 4'h0, 16'h0007}
  };
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  csil_op_t op = '0;
  logic psw_wr_en = 1'b0;
  logic [15:0] psw_wr_data = 16'h0;
  logic return_from_handler = 1'b0;
  logic [15:0] ret_psw = 16'h0;
  logic exc_wr_req = 1'b0;
  logic [15:0] req_set = 16'h0;
  logic [15:0] cpu_status_word, irq_req, cur_pc;
  logic [15:0] got_pc, exp_pc, got_psw, got_vec;
  logic [7:0] n_branch;
  logic [2:0] span;
  logic instr_boundary, exc_wr_grant, irq_o;
  csil_entry_t entry;
  logic [31:0] rd;
  int error_cnt = 0;
  int total_checks = 0;
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  csil_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .op(op), .psw_wr_en(psw_wr_en),
    .psw_wr_data(psw_wr_data), .instr_boundary(instr_boundary),
    .cur_pc(cur_pc), .return_from_handler(return_from_handler),
    .ret_psw(ret_psw), .cpu_status_word(cpu_status_word), .entry(entry),
    .exc_wr_req(exc_wr_req), .exc_wr_grant(exc_wr_grant),
    .irq_req(irq_req), .irq_o(irq_o));
  csil_core_model i_core (.hclk(hclk), .hresetn(hresetn), .entry(entry),
    .irq_req(irq_req), .instr_boundary(instr_boundary), .cur_pc(cur_pc),
    .req_set(req_set), .got_pc(got_pc), .exp_pc(exp_pc),
    .got_psw(got_psw), .got_vec(got_vec), .n_branch(n_branch),
    .span(span));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic run_op(input csil_row_t r);
    @(posedge hclk);
    op <= '{1'b1, r.kind, r.d[15:0], r.cho[2], r.cho[1], r.cho[0], r.idx};
    @(posedge hclk);
    op.valid <= 1'b0;
    #1;
  endtask : run_op
  task automatic wait_branch(input logic [7:0] n);
    for (int t = 0; t < 40 && n_branch !== n; t++) @(posedge hclk);
    #1;
    chk({24'h0, n_branch}, {24'h0, n});
  endtask : wait_branch
  task automatic pulse_wait(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : pulse_wait
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i].is_op) begin
        run_op(ROWS[i]);
        chk({16'h0, cpu_status_word}, {16'h0, ROWS[i].exp});
      end else begin
        bus(1'b1, ROWS[i].a, ROWS[i].d);
        bus(1'b0, ROWS[i].a, 32'h0);
        chk(rd, {16'h0, ROWS[i].exp});
      end
    end
    // second reset in mid-run must clear every level field
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
    // the row table left carry set, so a stale word would show here
    chk({16'h0, cpu_status_word}, {16'h0, `CSIL_PSW_RST});
    @(posedge hclk);
    hresetn <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      bus(1'b0, A_AL + 32'(4 * j), 32'h0);
      chk(rd, 32'h0);
    end
    bus(1'b1, A_AL, 32'h29);
    bus(1'b1, A_BH, 32'h03);
    req_set <= 16'h0007;
    bus(1'b1, A_PSW, 32'h0000);
    pulse_wait(8);
    chk({24'h0, n_branch}, 32'h0);
    bus(1'b1, A_PSW, 32'h0280);
    pulse_wait(8);
    chk({24'h0, n_branch}, 32'h0);
    @(posedge hclk);
    psw_wr_en <= 1'b1;
    psw_wr_data <= 16'h0180;
    @(posedge hclk);
    psw_wr_en <= 1'b0;
    wait_branch(8'h01);
    chk({16'h0, got_vec}, 32'h8004);
    chk({16'h0, got_pc}, {16'h0, exp_pc});
    chk({16'h0, got_psw}, 32'h0180);
    // span counts the cycles before the branch cycle
    chk({29'h0, span}, 32'(`CSIL_ENTRY_CYC - 1));
    chk({16'h0, cpu_status_word}, 32'h0280);
    @(posedge hclk);
    req_set <= 16'h1007;
    wait_branch(8'h02);
    chk({16'h0, got_vec}, 32'h8030);
    chk({16'h0, cpu_status_word}, 32'h0380);
    @(posedge hclk);
    req_set <= 16'h0000;
    return_from_handler <= 1'b1;
    ret_psw <= 16'h0180;
    @(posedge hclk);
    return_from_handler <= 1'b0;
    #1;
    chk({16'h0, cpu_status_word}, 32'h0180);
    @(posedge hclk);
    exc_wr_req <= 1'b1;
    pulse_wait(1);
    chk({31'h0, exc_wr_grant}, 32'h0);
    bus(1'b1, A_PSW, 32'h0800);
    pulse_wait(1);
    chk({31'h0, exc_wr_grant}, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    @(posedge hclk);
    exc_wr_req <= 1'b0;
    bus(1'b1, A_MASK, 32'h2);
    pulse_wait(2);
    chk({31'h0, irq_o}, 32'h1);
    bus(1'b1, A_STAT, 32'h2);
    pulse_wait(2);
    chk({31'h0, irq_o}, 32'h0);
    bus(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h5);
    chk({31'h0, hresp}, 32'h0);
    print_verdict();
  end
  // the whole run needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge hclk);
    error_cnt++;
    print_verdict();
  end
endmodule : csil_top_bench
